// File: logic/ampc_pkg.sv
// Package for the measurement and power control register bank.
// Assumes a 20 MHz APB clock; registers are byte wide in 32-bit words.
package ampc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [11:0] TIMING_IDX   = 12'h03d;
  localparam logic [11:0] ACQUISITION_SETTINGS_IDX  = 12'h03e;
  localparam logic [11:0] POWER_IDX    = 12'h03f;
  localparam logic [11:0] DETSTAT_IDX  = 12'h043;
  localparam logic [11:0] IRQSTAT_IDX  = 12'h044;
  localparam logic [11:0] IRQMASK_IDX  = 12'h045;
  localparam logic [11:0] DETCFG_IDX   = 12'h046;
  // Field positions
  localparam int WAKE_LSB      = 2;
  localparam int OCLK_EN_BIT   = 1;
  localparam int EXT_TRIG_BIT  = 0;
  localparam int OVR_DIS_BIT   = 7;
  localparam int AUTOSLEEP_BIT = 6;
  localparam int CHAIN_LSB     = 4;
  localparam int LOW_NOISE_BIT = 3;
  localparam int FAST_TW_BIT   = 7;
  localparam int IMPACT_BIT    = 5;
  localparam int SETTLE_BIT    = 4;
  localparam int LPF_BYP_BIT   = 3;
  localparam int HPF_BYP_BIT   = 2;
  // Reset values and writable masks
  localparam logic [7:0] TIMING_RST  = 8'h00;
  localparam logic [7:0] ACQUISITION_SETTINGS_RST = 8'h00;
  localparam logic [7:0] POWER_RST   = 8'h00;
  localparam logic [7:0] TIMING_WMSK = 8'h1f;
  localparam logic [7:0] POWER_WMSK  = 8'hbf;
  // Operating modes and chaining codes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE    = 2'h1;
  localparam logic [1:0] MODE_INSTANT = 2'h2;
  localparam logic [1:0] MODE_FULL    = 2'h3;
  localparam logic [1:0] CHAIN_DEFAULT = 2'h0;
  localparam logic [1:0] CHAIN_LINKED  = 2'h1;
  localparam logic [1:0] CHAIN_LOOPED  = 2'h2;
  // Interrupt status bits
  localparam int IRQ_ACT    = 0;
  localparam int IRQ_INACT  = 1;
  localparam int IRQ_ASLEEP = 2;
  localparam int IRQ_SETTLE = 3;
  // Times
  localparam int CLK_HZ          = 20000000;
  localparam int MS_PER_S        = 1000;
  localparam int MS_CYCLES       = CLK_HZ / MS_PER_S;
  localparam int SETTLE_LONG_MS  = 370;
  localparam int SETTLE_SHORT_MS = 16;
  localparam int SAMPLE_HZ       = 3200;
  localparam int SAMPLE_CYCLES   = CLK_HZ / SAMPLE_HZ;
  localparam logic [14:0] WAKE_MS [8] = '{15'd52, 15'd104, 15'd208, 15'd512,
                                          15'd2048, 15'd4096, 15'd8192, 15'd24576};
endpackage

// File: logic/ampc_top.sv
// Measurement and power control register bank with APB slave.
// Assumes detector event pulses and the irq pins come from outside;
// pin inputs are synchronised here, detector inputs are on pclk.
`timescale 1ns/1ps

// Functional notes
// - Wake timer code picks 52 to 24576 ms.
// - Outside clock on first pin paces sampling.
// - Outside trigger on second pin takes sample.
// - Autosleep enters wake-up mode on inactivity.
// - Autosleep ignored unless linked or looped.
// - Default chaining runs each enabled detector, host read acknowledges.
// - Linked chaining alternates, host read acknowledges.
// - Looped chaining alternates, acknowledged internally.
// - Chaining needs both detector enables, else default.
// - Quiet bit selects low noise operation.
// - Bandwidth code sets low-pass corner.
// - Speed bit selects fast two-wire mode.
// - Impact wake level picks instant-on threshold.
// - Settle bit picks 370 or 16 ms.
// - Lowpass bypass removes low-pass filter.
// - Highpass bypass removes high-pass filter.
// - Mode field selects standby, wake, instant, full.
// - Power control resets to zero.
module ampc_top #(
  parameter int MS_CYCLES     = ampc_pkg::MS_CYCLES,
  parameter int SAMPLE_CYCLES = ampc_pkg::SAMPLE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_irq_pin,
  input  wire logic        second_irq_pin,
  input  wire logic        activity_seen,
  input  wire logic        inactivity_seen,
  output logic             activity_arm,
  output logic             inactivity_arm,
  output logic             sample_tick,
  output logic             sample_request,
  output logic             wake_poll,
  output logic             filter_settling,
  output logic [1:0]       operating_mode,
  output logic [2:0]       bandwidth_code,
  output logic             quiet_operation,
  output logic             overrange_suppress,
  output logic             fast_two_wire_select,
  output logic             impact_wake_level,
  output logic             lowpass_bypass,
  output logic             highpass_bypass,
  output logic             irq
);
  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam int SMW = $clog2(SAMPLE_CYCLES + 1);

  if (MS_CYCLES < 2 || SAMPLE_CYCLES < 2) begin : g_bad_cycles
    $error("Cycle counts must be at least two");
  end

  typedef enum logic [1:0] {
    ARM_ACT   = 2'b01,
    ARM_INACT = 2'b10
  } ampc_chain_t;

  typedef struct packed {
    logic [7:0]  timing;
    logic [7:0]  acquisition_settings;
    logic [7:0]  power;
    logic        act_en;
    logic        inact_en;
    logic        act_flag;
    logic        inact_flag;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    ampc_chain_t chain;
    logic [2:0]  clk_sync;
    logic [2:0]  trg_sync;
    logic [MSW-1:0] ms_cnt;
    logic [14:0] wake_ms;
    logic [8:0]  settle_ms;
    logic        settling;
    logic [SMW-1:0] smp_cnt;
    logic        sample_tick;
    logic        sample_request;
    logic        wake_poll;
  } ampc_state_t;

  ampc_state_t st_reg;
  ampc_state_t st_next;

  logic        access;
  logic        wr;
  logic        rd;
  logic [11:0] idx;
  logic        hit;
  logic [1:0]  chain_eff;
  logic        linked;
  logic        act_evt;
  logic        inact_evt;
  logic        ms_tick;
  logic        clk_rise;
  logic        trg_rise;
  logic        asleep_evt;
  logic        wr_power;
  logic [7:0]  wbyte;

  // Zero-wait slave; ce low holds the access phase open
  assign pready = ce;
  assign access = psel && penable;
  assign wr     = access && pwrite && ce;
  assign rd     = access && !pwrite && ce;
  assign idx    = {2'b00, paddr[11:2]};
  assign wbyte  = pwdata[7:0];
  assign hit    = (paddr[1:0] == 2'b00) &&
                  (idx == ampc_pkg::TIMING_IDX || idx == ampc_pkg::ACQUISITION_SETTINGS_IDX ||
                   idx == ampc_pkg::POWER_IDX || idx == ampc_pkg::DETSTAT_IDX ||
                   idx == ampc_pkg::IRQSTAT_IDX || idx == ampc_pkg::IRQMASK_IDX ||
                   idx == ampc_pkg::DETCFG_IDX);
  assign pslverr = access && !hit;
  assign wr_power = wr && hit && pstrb[0] && idx == ampc_pkg::POWER_IDX;

  assign chain_eff = (st_reg.act_en && st_reg.inact_en &&
                      st_reg.acquisition_settings[ampc_pkg::CHAIN_LSB +: 2] != 2'h3) ?
                     st_reg.acquisition_settings[ampc_pkg::CHAIN_LSB +: 2] : ampc_pkg::CHAIN_DEFAULT;
  assign linked = chain_eff != ampc_pkg::CHAIN_DEFAULT;

  // one detector armed at a time when linked or looped; in default chaining each follows its own enable
  assign activity_arm   = linked ? (st_reg.chain == ARM_ACT)   : st_reg.act_en;
  assign inactivity_arm = linked ? (st_reg.chain == ARM_INACT) : st_reg.inact_en;
  assign act_evt   = ce && activity_seen && activity_arm;
  assign inact_evt = ce && inactivity_seen && inactivity_arm;

  assign asleep_evt = inact_evt && linked && st_reg.acquisition_settings[ampc_pkg::AUTOSLEEP_BIT] && !wr_power;

  assign ms_tick  = st_reg.ms_cnt == MSW'(MS_CYCLES - 1);
  // Edge detectors read only the second and third stages
  assign clk_rise = st_reg.clk_sync[1] && !st_reg.clk_sync[2];
  assign trg_rise = st_reg.trg_sync[1] && !st_reg.trg_sync[2];

  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.clk_sync = {st_reg.clk_sync[1:0], first_irq_pin};
      st_next.trg_sync = {st_reg.trg_sync[1:0], second_irq_pin};
      st_next.ms_cnt   = ms_tick ? '0 : st_reg.ms_cnt + MSW'(1);
      st_next.sample_tick    = 1'b0;
      st_next.sample_request = 1'b0;
      st_next.wake_poll      = 1'b0;

      // Register writes; byte lane 0 carries the data
      if (wr && hit && pstrb[0]) begin
        case (idx)
          ampc_pkg::TIMING_IDX: begin
            st_next.timing = wbyte & ampc_pkg::TIMING_WMSK;
          end
          ampc_pkg::ACQUISITION_SETTINGS_IDX: begin
            st_next.acquisition_settings = wbyte;
          end
          ampc_pkg::POWER_IDX: begin
            st_next.power = wbyte & ampc_pkg::POWER_WMSK;
          end
          ampc_pkg::IRQMASK_IDX: begin
            st_next.irq_mask = wbyte[3:0];
          end
          ampc_pkg::DETCFG_IDX: begin
            st_next.act_en   = wbyte[0];
            st_next.inact_en = wbyte[1];
          end
          ampc_pkg::IRQSTAT_IDX: begin
            st_next.irq_stat = st_reg.irq_stat & ~wbyte[3:0];
          end
          default: begin
          end
        endcase
      end

      if (rd && hit && idx == ampc_pkg::DETSTAT_IDX) begin
        st_next.act_flag   = 1'b0;
        st_next.inact_flag = 1'b0;
      end

      if (!linked) begin
        st_next.chain = ARM_ACT;
      end else begin
        case (st_reg.chain)
          ARM_ACT:   st_next.chain = act_evt ? ARM_INACT : ARM_ACT;
          ARM_INACT: st_next.chain = inact_evt ? ARM_ACT : ARM_INACT;
          default:   st_next.chain = ARM_ACT;
        endcase
      end

      if (chain_eff != ampc_pkg::CHAIN_LOOPED) begin
        if (act_evt) begin
          st_next.act_flag = 1'b1;
          st_next.irq_stat[ampc_pkg::IRQ_ACT] = 1'b1;
        end
        if (inact_evt) begin
          st_next.inact_flag = 1'b1;
          st_next.irq_stat[ampc_pkg::IRQ_INACT] = 1'b1;
        end
      end

      if (asleep_evt) begin
        st_next.power[1:0] = ampc_pkg::MODE_WAKE;
        st_next.irq_stat[ampc_pkg::IRQ_ASLEEP] = 1'b1;
      end

      if (wr_power && st_reg.power[1:0] == ampc_pkg::MODE_STANDBY &&
          wbyte[1:0] != ampc_pkg::MODE_STANDBY) begin
        st_next.settling  = 1'b1;
        st_next.settle_ms = wbyte[ampc_pkg::SETTLE_BIT] ?
                            9'(ampc_pkg::SETTLE_SHORT_MS) : 9'(ampc_pkg::SETTLE_LONG_MS);
      end else if (st_reg.settling && ms_tick) begin
        if (st_reg.settle_ms <= 9'd1) begin
          st_next.settling  = 1'b0;
          st_next.settle_ms = '0;
          st_next.irq_stat[ampc_pkg::IRQ_SETTLE] = 1'b1;
        end else begin
          st_next.settle_ms = st_reg.settle_ms - 9'd1;
        end
      end

      if (st_reg.power[1:0] != ampc_pkg::MODE_WAKE) begin
        st_next.wake_ms = '0;
      end else if (ms_tick) begin
        if (st_reg.wake_ms >= ampc_pkg::WAKE_MS[st_reg.timing[ampc_pkg::WAKE_LSB +: 3]] - 15'd1) begin
          st_next.wake_ms   = '0;
          st_next.wake_poll = 1'b1;
        end else begin
          st_next.wake_ms = st_reg.wake_ms + 15'd1;
        end
      end

      if (st_reg.power[1:0] == ampc_pkg::MODE_STANDBY) begin
        st_next.smp_cnt = '0;
      end else if (st_reg.timing[ampc_pkg::OCLK_EN_BIT]) begin
        st_next.smp_cnt     = '0;
        st_next.sample_tick = clk_rise;
      end else if (st_reg.smp_cnt == SMW'(SAMPLE_CYCLES - 1)) begin
        st_next.smp_cnt     = '0;
        st_next.sample_tick = 1'b1;
      end else begin
        st_next.smp_cnt = st_reg.smp_cnt + SMW'(1);
      end

      st_next.sample_request = st_reg.timing[ampc_pkg::EXT_TRIG_BIT] && trg_rise &&
                               st_reg.power[1:0] != ampc_pkg::MODE_STANDBY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.timing  <= ampc_pkg::TIMING_RST;
      st_reg.acquisition_settings <= ampc_pkg::ACQUISITION_SETTINGS_RST;
      st_reg.power   <= ampc_pkg::POWER_RST;
      st_reg.chain   <= ARM_ACT;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data from flops; unmapped or misaligned reads return zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit && !pwrite) begin
      case (idx)
        ampc_pkg::TIMING_IDX:  prdata[7:0] = st_reg.timing;
        ampc_pkg::ACQUISITION_SETTINGS_IDX: prdata[7:0] = st_reg.acquisition_settings;
        ampc_pkg::POWER_IDX:   prdata[7:0] = st_reg.power;
        ampc_pkg::DETSTAT_IDX: prdata[7:0] = {4'h0, linked, st_reg.chain == ARM_INACT,
                                              st_reg.inact_flag, st_reg.act_flag};
        ampc_pkg::IRQSTAT_IDX: prdata[7:0] = {4'h0, st_reg.irq_stat};
        ampc_pkg::IRQMASK_IDX: prdata[7:0] = {4'h0, st_reg.irq_mask};
        ampc_pkg::DETCFG_IDX:  prdata[7:0] = {6'h00, st_reg.inact_en, st_reg.act_en};
        default:               prdata = 32'h0000_0000;
      endcase
    end
  end

  assign irq                  = |(st_reg.irq_stat & st_reg.irq_mask);
  assign sample_tick          = st_reg.sample_tick;
  assign sample_request       = st_reg.sample_request;
  assign wake_poll            = st_reg.wake_poll;
  assign filter_settling      = st_reg.settling;
  assign operating_mode       = st_reg.power[1:0];
  assign bandwidth_code       = st_reg.acquisition_settings[2:0];
  assign quiet_operation      = st_reg.acquisition_settings[ampc_pkg::LOW_NOISE_BIT];
  assign overrange_suppress   = st_reg.acquisition_settings[ampc_pkg::OVR_DIS_BIT];
  assign fast_two_wire_select = st_reg.power[ampc_pkg::FAST_TW_BIT];
  assign impact_wake_level    = st_reg.power[ampc_pkg::IMPACT_BIT];
  assign lowpass_bypass       = st_reg.power[ampc_pkg::LPF_BYP_BIT];
  assign highpass_bypass      = st_reg.power[ampc_pkg::HPF_BYP_BIT];

  default clocking ast_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence trig_edge_seen;
    ce && trg_rise && st_reg.timing[ampc_pkg::EXT_TRIG_BIT] &&
      st_reg.power[1:0] != ampc_pkg::MODE_STANDBY;
  endsequence

  sequence inact_sleep_cause;
    asleep_evt;
  endsequence

  AST_RESERVED_ZERO: assert property (rd && idx == ampc_pkg::POWER_IDX |-> prdata[31:6] == '0 ||
                                      (prdata[31:8] == '0 && !prdata[6]))
    else $error("Reserved power bits read nonzero");
  AST_AUTOSLEEP_WAKE: assert property (inact_sleep_cause |=> operating_mode == ampc_pkg::MODE_WAKE &&
                                       st_reg.irq_stat[ampc_pkg::IRQ_ASLEEP])
    else $error("Autosleep did not enter wake-up mode");
  AST_AUTOSLEEP_IGNORED: assert property (!linked && !wr_power |=> $stable(operating_mode))
    else $error("Mode changed without chaining or write");
  AST_ONE_ARMED: assert property (linked |-> activity_arm != inactivity_arm)
    else $error("Chained detectors armed together");
  AST_LOOP_NO_LATCH: assert property (chain_eff == ampc_pkg::CHAIN_LOOPED && !st_reg.act_flag |=>
                                      !st_reg.act_flag)
    else $error("Looped event latched a flag");
  AST_DEFAULT_BOTH: assert property (!(st_reg.act_en && st_reg.inact_en) |->
                                     activity_arm == st_reg.act_en && inactivity_arm == st_reg.inact_en)
    else $error("Chaining active without both enables");
  AST_READ_ACK: assert property (rd && hit && idx == ampc_pkg::DETSTAT_IDX && !act_evt |=> !st_reg.act_flag)
    else $error("Status read did not acknowledge");
  AST_FLAG_HOLDS: assert property (st_reg.act_flag && !(rd && idx == ampc_pkg::DETSTAT_IDX) |=>
                                   st_reg.act_flag)
    else $error("Activity flag lost without read");
  AST_EXT_TRIGGER: assert property (trig_edge_seen |=> sample_request ##1 (!sample_request || !$past(ce)))
    else $error("Trigger did not give one sample");
  AST_EXT_CLOCK: assert property (ce && st_reg.timing[ampc_pkg::OCLK_EN_BIT] &&
                                  st_reg.power[1:0] != ampc_pkg::MODE_STANDBY |=> sample_tick == $past(clk_rise))
    else $error("Sample tick not from outside clock");
  AST_WAKE_MODE: assert property (wake_poll |-> $past(operating_mode) == ampc_pkg::MODE_WAKE)
    else $error("Wake poll outside wake-up mode");
endmodule

// File: tb/ampc_host_model.sv
// Host side model: APB master plus the drivers of the two irq pins.
// Assumes a single pclk domain; pins idle low between pulse trains.
`timescale 1ns/1ps
module ampc_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  output logic             first_irq_pin,
  output logic             second_irq_pin
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    first_irq_pin = 1'b0;
    second_irq_pin = 1'b0;
  end

  // Request held until pready seen; no fixed latency assumed
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pin_pulse(input logic second, input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      if (second)
        second_irq_pin <= 1'b1;
      else
        first_irq_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      first_irq_pin <= 1'b0;
      second_irq_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

// File: tb/accel_acquisition_settings_power_control_tb.sv
// Self-checking bench for the measurement and power control bank.
// Assumes short ms and sample counts so settle and wake fit the run.
`timescale 1ns/1ps
module accel_acquisition_settings_power_control_tb;
  localparam int MSC = 4;
  localparam logic [11:0] TIM = ampc_pkg::TIMING_IDX;
  localparam logic [11:0] MEA = ampc_pkg::ACQUISITION_SETTINGS_IDX;
  localparam logic [11:0] PWR = ampc_pkg::POWER_IDX;
  localparam logic [11:0] DST = ampc_pkg::DETSTAT_IDX;
  localparam logic [11:0] IST = ampc_pkg::IRQSTAT_IDX;
  localparam logic [11:0] IMK = ampc_pkg::IRQMASK_IDX;
  localparam logic [11:0] DCF = ampc_pkg::DETCFG_IDX;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, p1, p2, act, inact;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic aarm, iarm, stick, sreq, wpoll, fsettle, quiet, ovr, fast, impact, lpf, hpf, irq, er;
  logic [1:0] mode;
  logic [2:0] bw;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_req = 0;
  int n_tick = 0;
  int n;

  ampc_top #(.MS_CYCLES(MSC), .SAMPLE_CYCLES(8)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_irq_pin(p1), .second_irq_pin(p2), .activity_seen(act),
    .inactivity_seen(inact), .activity_arm(aarm), .inactivity_arm(iarm), .sample_tick(stick),
    .sample_request(sreq), .wake_poll(wpoll), .filter_settling(fsettle), .operating_mode(mode),
    .bandwidth_code(bw), .quiet_operation(quiet), .overrange_suppress(ovr),
    .fast_two_wire_select(fast), .impact_wake_level(impact), .lowpass_bypass(lpf),
    .highpass_bypass(hpf), .irq(irq));

  ampc_host_model host (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .first_irq_pin(p1), .second_irq_pin(p2));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (stick === 1'b1) n_tick++;
    if (sreq === 1'b1) n_req++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    host.xfer(1'b1, i << 2, {24'h0, d}, rd, er);
  endtask

  task automatic rdc(input string nm, input logic [11:0] i, input logic [7:0] e);
    host.xfer(1'b0, i << 2, 32'h0, rd, er);
    chk(nm, {24'h0, e}, rd);
  endtask

  // One-cycle detector event, then wait for its effect
  task automatic det(input logic is_inact);
    @(posedge pclk);
    act <= ~is_inact;
    inact <= is_inact;
    @(posedge pclk);
    act <= 1'b0;
    inact <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic t_reset();
    rdc("power", PWR, 8'h00);
    rdc("acquisition_settings", MEA, 8'h00);
    rdc("timing", TIM, 8'h00);
    chk("pwr_out", 32'h0, 32'({fast, impact, lpf, hpf, mode}));
  endtask

  task automatic t_power();
    int b [4] = '{7, 5, 3, 2};
    wr(PWR, 8'hff);
    rdc("power_rsvd", PWR, 8'hbf);
    for (int k = 0; k < 4; k++) begin
      wr(PWR, 8'(1 << b[k]));
      @(negedge pclk);
      chk("pwr_bit", 32'(6'h20 >> k), 32'({fast, impact, lpf, hpf, mode}));
    end
    for (int m = 0; m < 4; m++) begin
      wr(PWR, 8'(m));
      @(negedge pclk);
      chk("mode", 32'(m), 32'(mode));
    end
    wr(PWR, 8'h40);
    rdc("power_b6", PWR, 8'h00);
  endtask

  task automatic t_acquisition_settings();
    for (int c = 0; c < 5; c++) begin
      wr(MEA, 8'(c));
      @(negedge pclk);
      chk("bandwidth", 32'(c), 32'(bw));
    end
    wr(MEA, 8'h88);
    @(negedge pclk);
    chk("quiet_ovr", 32'h3, 32'({quiet, ovr}));
    wr(MEA, 8'h80);
    @(negedge pclk);
    chk("quiet_off", 32'h0, 32'(quiet));
    wr(TIM, 8'hff);
    rdc("timing", TIM, 8'h1f);
    host.xfer(1'b0, 12'h140, 32'h0, rd, er);
    chk("unmapped", 32'h1, {rd[30:0], er});
    host.xfer(1'b1, 12'h0f9, 32'hff, rd, er);
    chk("misalign", 32'h1, 32'(er));
    rdc("acquisition_settings", MEA, 8'h80);
  endtask

  task automatic t_settle();
    int ms;
    for (int s = 0; s < 2; s++) begin
      ms = s ? 16 : 370;
      wr(PWR, 8'h00);
      wr(IST, 8'h0f);
      wr(IMK, 8'h08);
      wr(PWR, s ? 8'h13 : 8'h03);
      @(negedge pclk);
      n = 0;
      while (fsettle === 1'b1 && n < 3000) begin
        @(negedge pclk);
        n++;
      end
      chk("settle_len", 32'h1, 32'(n > (ms - 1) * MSC && n <= ms * MSC));
      chk("irq_set", 32'h1, 32'(irq));
      rdc("irqstat", IST, 8'h08);
      wr(IMK, 8'h00);
      @(negedge pclk);
      chk("irq_masked", 32'h0, 32'(irq));
      wr(IMK, 8'h08);
      wr(IST, 8'h08);
      @(negedge pclk);
      chk("irq_clear", 32'h0, 32'(irq));
    end
    wr(IMK, 8'h00);
  endtask

  task automatic wait_poll();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wpoll !== 1'b1 && n < 5000);
  endtask

  task automatic t_wake();
    int wk [4] = '{52, 104, 208, 512};
    for (int c = 0; c < 4; c++) begin
      wr(PWR, 8'h00);
      wr(TIM, 8'(c << 2));
      wr(PWR, 8'h01);
      wait_poll();
      wait_poll();
      chk("wake_gap", 32'(wk[c] * MSC), 32'(n));
    end
  endtask

  task automatic t_chain();
    wr(PWR, 8'h00);
    wr(IST, 8'h0f);
    wr(DCF, 8'h03);
    wr(MEA, 8'h50);
    wr(PWR, 8'h03);
    @(negedge pclk);
    chk("arms", 32'h2, 32'({aarm, iarm}));
    det(1'b0);
    chk("arms", 32'h1, 32'({aarm, iarm}));
    rdc("detstat", DST, 8'h0d);
    rdc("detstat_ack", DST, 8'h0c);
    det(1'b1);
    chk("autosleep", 32'(ampc_pkg::MODE_WAKE), 32'(mode));
    rdc("irqstat", IST, 8'h07);
    rdc("detstat", DST, 8'h0a);
    wr(IST, 8'h0f);
    wr(MEA, 8'h20);
    det(1'b0);
    chk("arms_loop", 32'h1, 32'({aarm, iarm}));
    rdc("detstat_loop", DST, 8'h0c);
    rdc("irqstat_loop", IST, 8'h00);
    wr(MEA, 8'h40);
    wr(PWR, 8'h03);
    @(negedge pclk);
    chk("arms_dflt", 32'h3, 32'({aarm, iarm}));
    det(1'b1);
    chk("no_sleep", 32'h3, 32'(mode));
    wr(DCF, 8'h01);
    wr(MEA, 8'h10);
    det(1'b0);
    chk("arms_fallback", 32'h2, 32'({aarm, iarm}));
  endtask

  task automatic t_ext();
    wr(PWR, 8'h03);
    wr(TIM, 8'h02);
    repeat (2) @(negedge pclk);
    n_tick = 0;
    repeat (40) @(posedge pclk);
    chk("ticks_idle", 32'h0, 32'(n_tick));
    host.pin_pulse(1'b0, 3);
    repeat (6) @(posedge pclk);
    chk("ticks", 32'h3, 32'(n_tick));
    wr(TIM, 8'h01);
    @(negedge pclk);
    n_req = 0;
    host.pin_pulse(1'b1, 2);
    repeat (6) @(posedge pclk);
    chk("requests", 32'h2, 32'(n_req));
    wr(TIM, 8'h00);
    @(negedge pclk);
    n_req = 0;
    host.pin_pulse(1'b1, 1);
    repeat (6) @(posedge pclk);
    chk("req_off", 32'h0, 32'(n_req));
  endtask

  // Clock enable low stalls the access phase
  task automatic t_ce();
    ce <= 1'b0;
    fork
      wr(MEA, 8'h05);
      begin
        repeat (10) @(posedge pclk);
        chk("pready_low", 32'h0, 32'(pready));
        chk("ce_frozen", 32'h0, 32'(bw));
        ce <= 1'b1;
      end
    join
    @(negedge pclk);
    chk("ce_write", 32'h5, 32'(bw));
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    act = 1'b0;
    inact = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_power();
    t_acquisition_settings();
    t_settle();
    t_wake();
    t_chain();
    t_ext();
    t_ce();
    end_sim();
  end
endmodule
